// *** hdl/psdl_loader.sv ***
// Strap default loader: captures strap pins after reset and seeds the PHY
// and flow-control registers. Assumes strap pins are static around reset.
`timescale 1ns/10ps
module psdl_loader
    import psdl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Strap pins
    input wire logic port1_flowctl_select_strap,
    input wire logic port2_auto_crossover_strap,
    input wire logic port2_manual_crossover_strap,
    input wire logic port2_negotiation_strap,
    // Negotiated pause result for port 1
    input wire logic an_tx_pause,
    input wire logic an_rx_pause,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Resolved configuration
    output logic straps_loaded,
    output logic port1_flowctl_manual_select,
    output logic port1_tx_pause_eff,
    output logic port1_rx_pause_eff,
    output logic port1_pause_advert,
    output logic port2_crossover_auto,
    output logic port2_mdix_select,
    output logic negotiation_enable_bit,
    output logic speed_select_low_bit,
    output logic duplex_select_bit,
    output logic port2_adv_10fd,
    output logic port2_adv_10hd,
    output logic [2:0] port2_phy_mode
);
    psdl_state_type st_r;
    psdl_state_type st_nxt;
    logic [2:0] cnt_r;
    logic [NSTRAP-1:0] strap_s;
    logic [NSTRAP-1:0] cap_r;
    logic [2:0] p1fc_r;
    logic p1adv_r;
    logic [2:0] p2bas_r;
    logic [1:0] p2adv_r;
    logic [2:0] p2spc_r;
    logic [2:0] p2mode_r;
    logic [15:0] rdata_r;
    logic [15:0] rd_mux;
    logic [12:0] out_r;
    logic [12:0] out_nxt;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
        hit = (a == idx);
    endfunction

    psdl_sync u_sync (
        .clock(clock),
        .rst(rst),
        .pin_in({port2_negotiation_strap, port2_manual_crossover_strap,
                 port2_auto_crossover_strap, port1_flowctl_select_strap}),
        .level_out(strap_s)
    );

    // Decode
    wire load = (st_r == ST_LOAD);
    wire run = (st_r == ST_RUN);
    wire wr_fc = reg_wr && run && hit(reg_addr, REG_P1_FC);
    wire wr_adv1 = reg_wr && run && hit(reg_addr, REG_P1_ADV);
    wire wr_bas = reg_wr && run && hit(reg_addr, REG_P2_BASIC);
    wire wr_adv2 = reg_wr && run && hit(reg_addr, REG_P2_ADV);
    wire wr_spc = reg_wr && run && hit(reg_addr, REG_P2_SPC);
    wire wr_mode = reg_wr && run && hit(reg_addr, REG_P2_MODES);
    wire an_s = strap_s[S_AN];

    // Crossover resolution; strap is blind while override is set
    wire ovr = p2spc_r[2];
    wire x_auto = ovr ? p2spc_r[1] : cap_r[S_XAUTO]; // RULE4 RULE5
    wire x_mdix = ovr ? p2spc_r[0] : cap_r[S_XMAN]; // RULE6
    // Manual select picks the enable bits, else negotiation result
    wire p1_man = p1fc_r[0];
    wire tx_eff = p1_man ? p1fc_r[1] : an_tx_pause; // RULE2 RULE3
    wire rx_eff = p1_man ? p1fc_r[2] : an_rx_pause; // RULE2 RULE3

    // Loader sequence: wait for the synchronisers, load once, then run
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_SETTLE: st_nxt = (cnt_r == SETTLE_CYC) ? ST_LOAD : ST_SETTLE;
            ST_LOAD: st_nxt = ST_RUN; // RULE9
            ST_RUN: st_nxt = ST_RUN;
            default: st_nxt = ST_SETTLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_r <= ST_SETTLE;
            cnt_r <= 3'h0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= (st_r == ST_SETTLE) ? cnt_r + 3'h1 : cnt_r;
        end
    end

    // Strap snapshot, taken after release rather than at the reset edge
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cap_r <= STRAP_IDLE;
        else if (load)
            cap_r <= strap_s; // RULE9
    end

    // Port 1 flow control and advertisement
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            p1fc_r <= 3'h0;
            p1adv_r <= 1'h1;
        end
        else if (load)
        begin
            p1fc_r[0] <= strap_s[S_FC]; // RULE1
            p1adv_r <= !strap_s[S_FC]; // RULE2 RULE3
        end
        else
        begin
            if (wr_fc)
                p1fc_r <= {reg_wdata[B_FC_RX], reg_wdata[B_FC_TX], reg_wdata[B_FC_MANUAL]};
            if (wr_adv1)
                p1adv_r <= reg_wdata[B_ADV_PAUSE];
        end
    end

    // Port 2 basic control, advertisement and mode: negotiation-driven
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            p2bas_r <= {1'h1, 1'h1, 1'h1};
            p2adv_r <= 2'h3;
            p2mode_r <= MODE_AN;
        end
        else if (load)
        begin
            p2bas_r[2] <= an_s; // RULE7
            p2bas_r[1:0] <= an_s ? 2'h3 : {SPEED_FIXED, DUPLEX_FIXED}; // RULE8
            p2adv_r <= an_s ? 2'h3 : 2'h0; // RULE8
            p2mode_r <= an_s ? MODE_AN : MODE_FIXED; // RULE8
        end
        else
        begin
            if (wr_bas)
                p2bas_r <= {reg_wdata[B_BAS_AN], reg_wdata[B_BAS_SPEED], reg_wdata[B_BAS_DUPLEX]};
            if (wr_adv2)
                p2adv_r <= {reg_wdata[B_ADV_10FD], reg_wdata[B_ADV_10HD]};
            if (wr_mode)
                p2mode_r <= reg_wdata[B_MODE_LO +: 3];
        end
    end

    // Crossover control is software only; override defaults clear
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            p2spc_r <= 3'h0;
        else if (wr_spc)
            p2spc_r <= {reg_wdata[B_SPC_OVR], reg_wdata[B_SPC_AUTO], reg_wdata[B_SPC_MDIX]};
    end

    // Read mux; unmapped indices read zero
    always_comb
    begin
        rd_mux = RD_NONE;
        case (reg_addr)
            REG_P1_FC:
            begin
                rd_mux[B_FC_RX] = p1fc_r[2];
                rd_mux[B_FC_TX] = p1fc_r[1];
                rd_mux[B_FC_MANUAL] = p1fc_r[0];
            end
            REG_P1_ADV: rd_mux[B_ADV_PAUSE] = p1adv_r;
            REG_P2_BASIC:
            begin
                rd_mux[B_BAS_AN] = p2bas_r[2];
                rd_mux[B_BAS_SPEED] = p2bas_r[1];
                rd_mux[B_BAS_DUPLEX] = p2bas_r[0];
            end
            REG_P2_ADV:
            begin
                rd_mux[B_ADV_10FD] = p2adv_r[1];
                rd_mux[B_ADV_10HD] = p2adv_r[0];
            end
            REG_P2_SPC: rd_mux[B_SPC_OVR -: 3] = p2spc_r;
            REG_P2_MODES: rd_mux[B_MODE_LO +: 3] = p2mode_r;
            REG_STATUS: rd_mux[8:0] = {rx_eff, tx_eff, x_mdix, x_auto, cap_r, run};
            default: rd_mux = RD_NONE;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rdata_r <= RD_NONE;
        else
            rdata_r <= reg_rd ? rd_mux : RD_NONE;
    end

    // Every output is registered, one cycle behind its source
    assign out_nxt = {run, p1_man, tx_eff, rx_eff, p1adv_r, x_auto, x_mdix,
                      p2bas_r, p2adv_r, 1'h0};
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            out_r <= 13'h0;
        else
            out_r <= out_nxt;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            port2_phy_mode <= MODE_AN;
        else
            port2_phy_mode <= p2mode_r;
    end

    assign reg_rdata = rdata_r;
    assign straps_loaded = out_r[12];
    assign port1_flowctl_manual_select = out_r[11];
    assign port1_tx_pause_eff = out_r[10];
    assign port1_rx_pause_eff = out_r[9];
    assign port1_pause_advert = out_r[8];
    assign port2_crossover_auto = out_r[7];
    assign port2_mdix_select = out_r[6];
    assign negotiation_enable_bit = out_r[5];
    assign speed_select_low_bit = out_r[4];
    assign duplex_select_bit = out_r[3];
    assign port2_adv_10fd = out_r[2];
    assign port2_adv_10hd = out_r[1];

    // Load step followed by run, and a software write to the flow-control word clearing the manual select bit
    sequence seq_load;
        load ##1 run;
    endsequence
    sequence seq_wr_fc;
        wr_fc && !reg_wdata[B_FC_MANUAL];
    endsequence

    a_fc_select_load: assert property (@(posedge clock) disable iff (rst) // RULE1
        load |=> p1fc_r[0] == $past(strap_s[S_FC]))
        else $error("manual select not loaded from strap");
    a_pause_adv_low: assert property (@(posedge clock) disable iff (rst) // RULE2
        load && !strap_s[S_FC] |=> p1adv_r ##1 port1_pause_advert)
        else $error("pause advert not set for low strap");
    a_pause_adv_high: assert property (@(posedge clock) disable iff (rst) // RULE3
        load && strap_s[S_FC] |=> !p1adv_r && (tx_eff == p1fc_r[1]))
        else $error("pause advert or manual path wrong for high strap");
    a_xover_strap: assert property (@(posedge clock) disable iff (rst) // RULE4
        run && !ovr |=> port2_crossover_auto == $past(cap_r[S_XAUTO]))
        else $error("crossover auto not from strap");
    a_xover_override: assert property (@(posedge clock) disable iff (rst) // RULE5
        ovr |=> port2_crossover_auto == $past(p2spc_r[1]))
        else $error("strap leaked through override");
    a_mdix_manual: assert property (@(posedge clock) disable iff (rst) // RULE6
        run && !ovr && !cap_r[S_XAUTO] |=> port2_mdix_select == $past(cap_r[S_XMAN]))
        else $error("manual crossover select wrong");
    a_neg_enable: assert property (@(posedge clock) disable iff (rst) // RULE7
        load |=> p2bas_r[2] == $past(an_s) ##1 negotiation_enable_bit == $past(an_s, 2))
        else $error("negotiation enable not from strap");
    a_mode_shape: assert property (@(posedge clock) disable iff (rst) // RULE8
        load |=> p2mode_r == ($past(an_s) ? MODE_AN : MODE_FIXED) && p2adv_r == {2{$past(an_s)}})
        else $error("mode or advert defaults wrong");
    a_load_once: assert property (@(posedge clock) disable iff (rst) // RULE9
        seq_load |-> run [*8])
        else $error("loader left run state");
    a_write_wins: assert property (@(posedge clock) disable iff (rst) // RULE9
        seq_wr_fc |=> !p1fc_r[0] ##1 !port1_flowctl_manual_select)
        else $error("software write did not take precedence");
endmodule

// *** hdl/psdl_sync.sv ***
// Three-stage pin synchroniser for a group of strap levels.
// Assumes inputs are asynchronous to clock; output moves once stages 2 and 3 agree.
`timescale 1ns/10ps
module psdl_sync
    import psdl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Raw pins and filtered levels
    input wire logic [NSTRAP-1:0] pin_in,
    output logic [NSTRAP-1:0] level_out
);
    logic [NSTRAP-1:0] s1_r;
    logic [NSTRAP-1:0] s2_r;
    logic [NSTRAP-1:0] s3_r;
    logic [NSTRAP-1:0] lvl_r;
    logic [NSTRAP-1:0] lvl_nxt;

    // Take a bit only when the last two stages agree
    assign lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    assign level_out = lvl_r;

    // Stage 1 feeds only stage 2
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s1_r <= STRAP_IDLE;
            s2_r <= STRAP_IDLE;
            s3_r <= STRAP_IDLE;
            lvl_r <= STRAP_IDLE;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end
endmodule

// *** inc/psdl_pkg.sv ***
// Constants, register map and field layout for the strap default loader.
// Assumes one 40 MHz clock and a word-indexed register port of 16-bit data.
// Overview of operation
// RULE1: The port 1 flow-control select strap gives the reset default of the manual select bit, and it idles at zero.
// RULE2: With that strap low, pause comes from negotiation and symmetric pause advertisement bit 10 defaults to one.
// RULE3: With that strap high, pause follows the port 1 transmit and receive enables and bit 10 defaults to zero.
// RULE4: While the port 2 crossover override bit is clear, the auto-crossover strap turns automatic crossover off when low and on when high.
// RULE5: While the override bit is set, the auto-crossover strap is ignored completely.
// RULE6: With auto-crossover strap low and override clear, the manual crossover strap picks MDI for 0 and MDIX for 1, idling at 0.
// RULE7: The port 2 negotiation strap gives the reset default of the negotiation enable bit, off when low, on when high, idling at one.
// RULE8: The negotiation strap also shapes the defaults of speed low bit, duplex, advert bits 6 and 5 and the 3-bit mode field.
// The loader gives speed low bit and duplex a default of one for either strap level.
// RULE9: Straps are captured once after reset release and loaded as defaults, and later software writes stand until the next reset.
package psdl_pkg;
    // Register indices
    localparam logic [3:0] REG_P1_FC = 4'h0;
    localparam logic [3:0] REG_P1_ADV = 4'h1;
    localparam logic [3:0] REG_P2_BASIC = 4'h2;
    localparam logic [3:0] REG_P2_ADV = 4'h3;
    localparam logic [3:0] REG_P2_SPC = 4'h4;
    localparam logic [3:0] REG_P2_MODES = 4'h5;
    localparam logic [3:0] REG_STATUS = 4'h6;
    // Field positions
    localparam int B_FC_MANUAL = 0;
    localparam int B_FC_TX = 1;
    localparam int B_FC_RX = 2;
    localparam int B_ADV_PAUSE = 10;
    localparam int B_ADV_10FD = 6;
    localparam int B_ADV_10HD = 5;
    localparam int B_BAS_AN = 12;
    localparam int B_BAS_SPEED = 13;
    localparam int B_BAS_DUPLEX = 8;
    localparam int B_SPC_OVR = 15;
    localparam int B_SPC_AUTO = 14;
    localparam int B_SPC_MDIX = 13;
    localparam int B_MODE_LO = 5;
    // Strap vector positions
    localparam int S_FC = 0;
    localparam int S_XAUTO = 1;
    localparam int S_XMAN = 2;
    localparam int S_AN = 3;
    localparam int NSTRAP = 4;
    // Idle strap values, used until capture
    localparam logic [3:0] STRAP_IDLE = 4'h8;
    // Mode field defaults
    localparam logic [2:0] MODE_AN = 3'h7;
    localparam logic [2:0] MODE_FIXED = 3'h3;
    localparam logic SPEED_FIXED = 1'h1;
    localparam logic DUPLEX_FIXED = 1'h1;
    // Cycles allowed for the pin synchronisers to fill after reset
    localparam logic [2:0] SETTLE_CYC = 3'h4;
    localparam logic [15:0] RD_NONE = 16'h0000;
    // Loader sequence
    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } psdl_state_type;
endpackage

// *** verif/tb.sv ***
// Self-checking bench for the strap default loader: random strap sets across resets,
// refused early writes, late pin changes, software overrides and register reads.
// Assumes a single 40 MHz clock and the register port timing of the design.
`timescale 1ns/10ps
module tb;
    import psdl_pkg::*;
    // Design signals
    logic clock;
    logic rst;
    logic port1_flowctl_select_strap;
    logic port2_auto_crossover_strap;
    logic port2_manual_crossover_strap;
    logic port2_negotiation_strap;
    logic an_tx_pause;
    logic an_rx_pause;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic straps_loaded;
    logic port1_flowctl_manual_select;
    logic port1_tx_pause_eff;
    logic port1_rx_pause_eff;
    logic port1_pause_advert;
    logic port2_crossover_auto;
    logic port2_mdix_select;
    logic negotiation_enable_bit;
    logic speed_select_low_bit;
    logic duplex_select_bit;
    logic port2_adv_10fd;
    logic port2_adv_10hd;
    logic [2:0] port2_phy_mode;
    // Bench state
    int err_count;
    int num_checks;
    int cyc;
    logic [3:0] s;
    logic [15:0] d;
    logic [15:0] rd;
    logic t;
    logic r;

    psdl_loader u_psdl_loader (
        .clock, .rst, .port1_flowctl_select_strap, .port2_auto_crossover_strap,
        .port2_manual_crossover_strap, .port2_negotiation_strap, .an_tx_pause,
        .an_rx_pause, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .straps_loaded, .port1_flowctl_manual_select, .port1_tx_pause_eff,
        .port1_rx_pause_eff, .port1_pause_advert, .port2_crossover_auto,
        .port2_mdix_select, .negotiation_enable_bit, .speed_select_low_bit,
        .duplex_select_bit, .port2_adv_10fd, .port2_adv_10hd, .port2_phy_mode
    );

    // Clock source
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Hang guard; a full run needs well under a tenth of this
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            end_sim();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe, master changes after the edge
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdreg(input logic [3:0] a, output logic [15:0] v);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Status word after load: {rx_eff, tx_eff, mdix, auto, neg, man, auto, fc, loaded}
    function automatic logic [15:0] exp_status(input logic [3:0] st, input logic tp,
        input logic rp);
        return {7'h00, st[S_FC] ? 1'b0 : rp, st[S_FC] ? 1'b0 : tp, st[S_XMAN],
            st[S_XAUTO], st[S_AN], st[S_XMAN], st[S_XAUTO], st[S_FC], 1'b1};
    endfunction

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence: every strap combination, then random ones
    initial
    begin
        rst = 1'b1;
        {port2_negotiation_strap, port2_manual_crossover_strap} = 2'b10;
        {port2_auto_crossover_strap, port1_flowctl_select_strap} = 2'b00;
        {an_tx_pause, an_rx_pause, reg_wr, reg_rd} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        err_count = 0;
        num_checks = 0;
        cyc = 0;
        d = 16'($urandom(4));
        for (int i = 0; i < 24; i++)
        begin
            s = (i < 16) ? i[3:0] : 4'($urandom);
            t = 1'($urandom);
            r = 1'($urandom);
            @(posedge clock);
            rst <= 1'b1;
            {port2_negotiation_strap, port2_manual_crossover_strap} <= {s[S_AN], s[S_XMAN]};
            {port2_auto_crossover_strap, port1_flowctl_select_strap} <= {s[S_XAUTO], s[S_FC]};
            {an_tx_pause, an_rx_pause} <= {t, r};
            repeat ((i == 0) ? 10 : 3) @(posedge clock);
            rst <= 1'b0;
            // Write during settle must be dropped
            wr(REG_P1_FC, 16'h0007);
            #1;
            check(straps_loaded, 1'b0);
            // Poll off the edge so the flag is seen settled
            for (int k = 0; k < 20 && straps_loaded !== 1'b1; k++)
            begin
                @(posedge clock);
                #1;
            end
            repeat (2) @(posedge clock);
            #1;
            check(straps_loaded, 1'b1);
            check(port1_flowctl_manual_select, s[S_FC]);
            check(port1_pause_advert, !s[S_FC]);
            check({port1_tx_pause_eff, port1_rx_pause_eff}, s[S_FC] ? 2'b00 : {t, r});
            check(port2_crossover_auto, s[S_XAUTO]);
            if (!s[S_XAUTO])
                check(port2_mdix_select, s[S_XMAN]);
            check(negotiation_enable_bit, s[S_AN]);
            check({speed_select_low_bit, duplex_select_bit},
                s[S_AN] ? 2'h3 : {SPEED_FIXED, DUPLEX_FIXED});
            check({port2_adv_10fd, port2_adv_10hd}, {s[S_AN], s[S_AN]});
            check(port2_phy_mode, s[S_AN] ? MODE_AN : MODE_FIXED);
            rdreg(REG_STATUS, rd);
            check(rd, exp_status(s, t, r));
            // Read data must fall back to zero after its one cycle
            @(posedge clock);
            #1;
            check(reg_rdata, RD_NONE);
            // Pins move after load; captured defaults must hold
            @(posedge clock);
            {port2_negotiation_strap, port2_manual_crossover_strap} <= ~{s[S_AN], s[S_XMAN]};
            {port2_auto_crossover_strap, port1_flowctl_select_strap} <= ~{s[S_XAUTO], s[S_FC]};
            repeat (8) @(posedge clock);
            #1;
            check({port2_crossover_auto, port1_flowctl_manual_select},
                {s[S_XAUTO], s[S_FC]});
            check(negotiation_enable_bit, s[S_AN]);
            // Software overrides, one write strobe every other cycle
            d = $urandom;
            wr(REG_P1_FC, {13'h0000, d[2:0]});
            wr(REG_P2_SPC, {1'b1, d[4], d[5], 13'h0000});
            wr(REG_P2_BASIC, {3'h0, d[6], 12'h000});
            wr(REG_P1_ADV, {5'h00, d[7], 10'h000});
            wr(REG_P2_ADV, {9'h000, d[8], d[9], 5'h00});
            wr(REG_P2_MODES, {8'h00, d[12:10], 5'h00});
            repeat (3) @(posedge clock);
            #1;
            check(port1_pause_advert, d[7]);
            check({speed_select_low_bit, duplex_select_bit}, 2'h0);
            check({port2_adv_10fd, port2_adv_10hd}, {d[8], d[9]});
            check(port2_phy_mode, d[12:10]);
            check(port1_flowctl_manual_select, d[0]);
            check(port1_tx_pause_eff, d[0] ? d[1] : t);
            check(port1_rx_pause_eff, d[0] ? d[2] : r);
            check({port2_crossover_auto, port2_mdix_select}, {d[4], d[5]});
            check(negotiation_enable_bit, d[6]);
            rdreg(REG_P1_FC, rd);
            check(rd, {13'h0000, d[2:0]});
            rdreg(REG_P2_SPC, rd);
            check(rd, {1'b1, d[4], d[5], 13'h0000});
            wr(4'hf, 16'hffff);
            rdreg(4'hf, rd);
            check(rd, RD_NONE);
        end
        end_sim();
    end
endmodule
